/* File: hdl/sar_conversion_sequencer.sv */
// successive-approximation conversion sequencer with result buffer
module sar_conversion_sequencer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start_conv,
  input wire logic comp_keep,
  input wire logic short_cycle_n,
  input wire logic ext_clk_mode,
  input wire logic twos_comp_sel,
  input wire logic [1:0] rate_sel,
  output logic [11:0] par_out,
  output logic serial_out,
  output logic status_out,
  output logic clk_out,
  output logic result_valid,
  input wire logic result_ready,
  output sar_pkg::result_s result_data
);
  import sar_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  pins_s pin_raw;
  pins_s meta_ff;
  pins_s sync_ff;
  logic start_prev_ff;
  logic start_fall;

  assign pin_raw = {start_conv, comp_keep, short_cycle_n, ext_clk_mode, twos_comp_sel, rate_sel};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= pin_raw;
      sync_ff <= meta_ff;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      start_prev_ff <= 1'b0;
    end else begin
      start_prev_ff <= sync_ff.start;
    end
  end

  assign start_fall = start_prev_ff && !sync_ff.start;

  // ****************************************************************
  // internal conversion clock
  // ****************************************************************
  logic [4:0] per_sel;
  logic [4:0] div_ff;
  logic tick;
  logic clk_out_ff;

  always_comb begin
    case (sync_ff.rate)
      RATE_10: per_sel = PER10;
      RATE_8: per_sel = PER8;
      default: per_sel = PER12;
    endcase
  end

  assign tick = (div_ff >= per_sel - 5'h01);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_ff <= 5'h00;
    end else if (start_fall || tick) begin
      div_ff <= 5'h00;
    end else begin
      div_ff <= div_ff + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clk_out_ff <= 1'b0;
    end else begin
      clk_out_ff <= (div_ff < CLKOUT_CYC);
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  seq_state_e state_ff;
  logic [11:0] sar_ff;
  logic [3:0] idx_ff;
  logic [3:0] nbits_ff;
  logic first_ff;
  logic [2:0] settle_ff;
  logic step;
  logic dec_step;
  logic abandon;
  logic short_stop;
  logic fifo_ready;
  logic [11:0] code_fmt;

  // external mode: every falling request edge during conversion is one step
  assign step = (state_ff == st_conv) && (sync_ff.ext_mode ? start_fall : tick);
  assign dec_step = step && !first_ff && !short_stop;
  assign abandon = !sync_ff.ext_mode && sync_ff.start;
  assign short_stop = (state_ff == st_conv) && !first_ff && !abandon
                      && (settle_ff == SC_SETTLE) && !sync_ff.short_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settle_ff <= 3'h0;
    end else if (step || start_fall) begin
      settle_ff <= 3'h0;
    end else if (settle_ff != SC_SETTLE) begin
      settle_ff <= settle_ff + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= st_idle;
      sar_ff <= SAR_RST;
      idx_ff <= MSB_IDX;
      nbits_ff <= 4'h0;
      first_ff <= 1'b1;
    end else begin
      case (state_ff)
        st_idle, st_hold: begin
          if (abandon) begin
            state_ff <= st_hold;
          end else if (start_fall) begin
            state_ff <= st_conv;
            sar_ff <= SAR_RST;
            idx_ff <= MSB_IDX;
            nbits_ff <= 4'h0;
            // external mode: starting edge already sets first trial
            first_ff <= !sync_ff.ext_mode;
            if (sync_ff.ext_mode) begin
              sar_ff[MSB_IDX] <= 1'b1;
            end
          end
        end
        st_conv: begin
          if (abandon) begin
            state_ff <= st_hold;
          end else if (short_stop) begin
            sar_ff[idx_ff] <= 1'b0;
            state_ff <= st_push;
          end else if (step && first_ff) begin
            sar_ff[MSB_IDX] <= 1'b1;
            first_ff <= 1'b0;
          end else if (dec_step) begin
            sar_ff[idx_ff] <= sync_ff.comp;
            nbits_ff <= nbits_ff + 4'h1;
            if (idx_ff == 4'h0) begin
              state_ff <= st_push;
            end else begin
              idx_ff <= idx_ff - 4'h1;
              sar_ff[idx_ff - 4'h1] <= 1'b1;
            end
          end
        end
        st_push: begin
          if (abandon) begin
            state_ff <= st_hold;
          end else if (fifo_ready) begin
            state_ff <= st_idle;
          end
        end
        default: state_ff <= st_idle;
      endcase
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic [11:0] par_ff;
  logic serial_ff;
  logic status_ff;

  assign code_fmt = {sync_ff.two_comp ? sar_ff[11] : ~sar_ff[11], ~sar_ff[10:0]};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      par_ff <= PAR_RST;
    end else if (state_ff == st_conv || state_ff == st_push) begin
      par_ff <= code_fmt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      serial_ff <= 1'b1;
    end else if (dec_step) begin
      serial_ff <= !sync_ff.comp;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_ff <= 1'b1;
    end else begin
      status_ff <= (state_ff != st_idle) || abandon;
    end
  end

  assign par_out = par_ff;
  assign serial_out = serial_ff;
  assign status_out = status_ff;
  assign clk_out = clk_out_ff;

  // ****************************************************************
  // result buffer
  // ****************************************************************
  result_s push_data;

  assign push_data = '{nbits: nbits_ff, code: code_fmt};

  result_fifo #(
    .WIDTH(RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(state_ff == st_push && !abandon),
    .in_ready(fifo_ready),
    .in_data(push_data),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(result_data)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [8:0] conv_cnt_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conv_cnt_ff <= 9'h000;
    end else if (state_ff != st_conv) begin
      conv_cnt_ff <= 9'h000;
    end else if (conv_cnt_ff != 9'h1FF) begin
      conv_cnt_ff <= conv_cnt_ff + 9'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_start_restart: assert property (
    start_fall && !sync_ff.ext_mode |=> state_ff == st_conv && sar_ff == SAR_RST ##1 first_ff)
    else $error("falling request did not restart the sequencer");

  a_abandon_hold: assert property (
    state_ff == st_conv && abandon |=> state_ff == st_hold && status_ff)
    else $error("request high did not abandon conversion");

  a_conv12_time: assert property (
    !sync_ff.ext_mode && sync_ff.rate == RATE_12 |-> conv_cnt_ff <= CONV12_CYC)
    else $error("full conversion too long");

  a_conv8_time: assert property (
    !sync_ff.ext_mode && sync_ff.rate == RATE_8 && $stable(sync_ff.rate)
    |-> conv_cnt_ff <= CONV8_CYC)
    else $error("eight bit conversion too long");

  a_par_hold: assert property (
    state_ff != st_conv && $past(state_ff) != st_conv && $past(state_ff) != st_push
    |-> $stable(par_ff))
    else $error("parallel output changed while idle");

  a_par_coding: assert property (
    state_ff == st_conv |=> par_ff[10:0] == ~$past(sar_ff[10:0])
    && par_ff[11] == ($past(sync_ff.two_comp) ~^ $past(sar_ff[11])))
    else $error("parallel coding not complementary");

  a_serial_dec: assert property (
    dec_step |=> serial_ff == !$past(sync_ff.comp) && sar_ff[$past(idx_ff)] == $past(sync_ff.comp))
    else $error("serial decision does not match result bit");

  a_status_busy: assert property (
    state_ff == st_conv ##1 state_ff == st_conv |-> status_ff)
    else $error("status low during conversion");

  a_status_done: assert property (
    state_ff == st_idle && !abandon |=> !status_ff)
    else $error("status high after completion");

  a_clkout_pulse: assert property (
    disable iff (!nrst || start_fall)
    $rose(clk_out_ff) |-> clk_out_ff [*3] ##1 !clk_out_ff)
    else $error("clock out pulse width wrong");

  a_next_trial: assert property (
    dec_step && idx_ff != 4'h0 && !abandon
    |=> idx_ff == $past(idx_ff) - 4'h1 && sar_ff[idx_ff])
    else $error("next trial bit not set");

  a_short_stop: assert property (
    short_stop |=> state_ff == st_push && !sar_ff[$past(idx_ff)])
    else $error("short cycle did not end conversion");

  a_ext_steps: assert property (
    sync_ff.ext_mode && state_ff == st_conv && !start_fall && !short_stop |=> $stable(sar_ff))
    else $error("external mode stepped without a request pulse");

  a_fifo_stall: assert property (
    state_ff == st_push && !fifo_ready && !abandon |=> state_ff == st_push)
    else $error("result dropped while buffer full");

endmodule

/* File: hdl/sar_pkg.sv */
// constants and types of the successive-approximation conversion sequencer
package sar_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_NS = 40;
  localparam int RES_BITS = 12;
  localparam int CONV12_NS = 8000;
  localparam int CONV10_NS = 6000;
  localparam int CONV8_NS = 4000;
  localparam int INT_CLK_KHZ = 1500;
  localparam int CLKOUT_NS = 100;
  localparam int START_MIN_NS = 100;
  // period chosen so that N+1 periods plus short-cycle settling fit the limit
  localparam logic [4:0] PER12 = 5'(CONV12_NS / ((12 + 2) * CLK_NS));
  localparam logic [4:0] PER10 = 5'(CONV10_NS / ((10 + 2) * CLK_NS));
  localparam logic [4:0] PER8 = 5'(CONV8_NS / ((8 + 2) * CLK_NS));
  localparam logic [4:0] CLKOUT_CYC = 5'((CLKOUT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] CONV12_CYC = 9'(CONV12_NS / CLK_NS);
  localparam logic [8:0] CONV10_CYC = 9'(CONV10_NS / CLK_NS);
  localparam logic [8:0] CONV8_CYC = 9'(CONV8_NS / CLK_NS);
  localparam logic [8:0] START_MIN_CYC = 9'((START_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] SC_SETTLE = 3'h4;

  // ****************************************************************
  // codes and reset values
  // ****************************************************************
  localparam logic [1:0] RATE_12 = 2'h0;
  localparam logic [1:0] RATE_10 = 2'h1;
  localparam logic [1:0] RATE_8 = 2'h2;
  localparam logic [11:0] SAR_RST = 12'h000;
  localparam logic [11:0] PAR_RST = 12'hFFF;
  localparam logic [3:0] MSB_IDX = 4'hB;
  localparam int FIFO_DEPTH = 8;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [3:0] nbits;
    logic [11:0] code;
  } result_s;

  localparam int RESULT_W = $bits(result_s);

  typedef struct packed {
    logic start;
    logic comp;
    logic short_n;
    logic ext_mode;
    logic two_comp;
    logic [1:0] rate;
  } pins_s;

  typedef enum {st_idle, st_hold, st_conv, st_push} seq_state_e;

endpackage

/* File: hdl/result_fifo.sv */
// result buffer with valid/ready on both sides
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != (AW + 1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_ff];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule

/* File: sim/host_model.sv */
// host and comparator model facing the conversion sequencer
module host_model (
  input wire logic clk,
  input wire logic [11:0] par_out,
  input wire logic twos,
  input wire logic [11:0] target,
  output logic start_conv,
  output logic comp_keep
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] trial;
  initial start_conv = 1'b1;
  // request held high n cycles, then the falling edge
  task automatic pulse(input int n);
    start_conv <= 1'b1;
    repeat (n) @(posedge clk);
    start_conv <= 1'b0;
    @(posedge clk);
  endtask
  // comparator keeps a trial that does not exceed the input
  assign trial = twos ? {par_out[11], ~par_out[10:0]} : ~par_out;
  assign comp_keep = (trial <= target);
endmodule

/* File: sim/tb_sar_conversion_sequencer.sv */
// self-checking bench of the conversion sequencer
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module tb_sar_conversion_sequencer;
  import sar_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, start_conv, comp_keep, short_cycle_n, ext, twos, sc_en, last;
  logic [1:0] rate;
  logic [3:0] sc_idx;
  logic [11:0] target, par_out;
  logic serial_out, status_out, clk_out, result_valid, result_ready;
  result_s result_data;
  int miscompares, comparisons, tog;

  sar_conversion_sequencer uut (.clk(clk), .nrst(nrst), .start_conv(start_conv),
    .comp_keep(comp_keep), .short_cycle_n(short_cycle_n), .ext_clk_mode(ext),
    .twos_comp_sel(twos), .rate_sel(rate), .par_out(par_out), .serial_out(serial_out),
    .status_out(status_out), .clk_out(clk_out), .result_valid(result_valid),
    .result_ready(result_ready), .result_data(result_data));
  host_model host (.clk(clk), .par_out(par_out), .twos(twos), .target(target),
    .start_conv(start_conv), .comp_keep(comp_keep));
  // short-cycle pin wired to the output bit after the last wanted one
  assign short_cycle_n = sc_en ? par_out[sc_idx] : 1'b1;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) begin
    if (serial_out !== last) tog++;
    last = serial_out;
  end

  function automatic int exp_tog(input logic p, input logic [11:0] c);
    int n;
    n = 0;
    for (int i = 11; i >= 0; i--) begin
      if (~c[i] != p) n++;
      p = ~c[i];
    end
    return n;
  endfunction

  task automatic end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one conversion, timed from the falling request edge
  task automatic conv(input logic [11:0] t, input int lim);
    int n;
    target <= t;
    host.pulse(3);
    tog = 0;
    n = 1;
    while (status_out !== 1'b0 && n <= lim + 40) begin
      `CHK("status busy", 1'b1, status_out)
      @(posedge clk);
      n++;
    end
    // status read at an edge shows the value set one edge earlier
    `CHK("conversion in time", 1'b1, (n - 1) <= lim)
  endtask

  task automatic pop(input logic [3:0] nb, input logic [11:0] c);
    int n;
    n = 0;
    while (result_valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    `CHK("result nbits", nb, result_data.nbits)
    `CHK("result code", c, result_data.code)
    result_ready <= 1'b1;
    @(posedge clk);
    result_ready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_full;
    logic p;
    p = serial_out;
    conv(12'hA55, CONV12_CYC);
    `CHK("parallel word", ~12'hA55, par_out)
    `CHK("serial toggles", exp_tog(p, 12'hA55), tog)
    pop(4'hC, ~12'hA55);
    repeat (30) @(posedge clk);
    `CHK("parallel held", ~12'hA55, par_out)
  endtask

  task automatic t_twos;
    logic p;
    twos <= 1'b1;
    p = serial_out;
    conv(12'h3C7, CONV12_CYC);
    `CHK("twos word", {1'b0, ~11'h3C7}, par_out)
    `CHK("twos serial", exp_tog(p, 12'h3C7), tog)
    pop(4'hC, {1'b0, ~11'h3C7});
    twos <= 1'b0;
  endtask

  task automatic t_short;
    logic [11:0] m;
    for (int k = 0; k < 2; k++) begin
      m = (k == 0) ? 12'hFFC : 12'hFF0;
      rate <= (k == 0) ? RATE_10 : RATE_8;
      sc_idx <= (k == 0) ? 4'h1 : 4'h3;
      sc_en <= 1'b1;
      conv(12'h9B6, (k == 0) ? CONV10_CYC : CONV8_CYC);
      `CHK("short word", ~(12'h9B6 & m), par_out)
      pop((k == 0) ? 4'hA : 4'h8, ~(12'h9B6 & m));
    end
    sc_en <= 1'b0;
    rate <= RATE_12;
  endtask

  task automatic t_abandon;
    target <= 12'h123;
    host.pulse(3);
    repeat (100) @(posedge clk);
    conv(12'h456, CONV12_CYC);
    pop(4'hC, ~12'h456);
    `CHK("nothing left", 1'b0, result_valid)
  endtask

  task automatic t_ext;
    ext <= 1'b1;
    target <= 12'h5A3;
    for (int i = 0; i < 13; i++) begin
      if (i == 12) `CHK("ext busy", 1'b1, status_out)
      host.pulse(3);
      repeat (15) @(posedge clk);
    end
    `CHK("ext done", 1'b0, status_out)
    `CHK("ext word", ~12'h5A3, par_out)
    pop(4'hC, ~12'h5A3);
    ext <= 1'b0;
    host.pulse(3);
    repeat (CONV12_CYC) @(posedge clk);
    pop(4'hC, ~12'h5A3);
  endtask

  task automatic t_clk;
    int h, p;
    h = 0;
    p = 0;
    while (clk_out !== 1'b0 && p < 40) begin @(posedge clk); p++; end
    while (clk_out !== 1'b1 && p < 80) begin @(posedge clk); p++; end
    p = 0;
    while (clk_out === 1'b1 && p < 40) begin @(posedge clk); h++; p++; end
    while (clk_out !== 1'b1 && p < 40) begin @(posedge clk); p++; end
    `CHK("clock pulse", int'(CLKOUT_CYC), h)
    `CHK("clock period", int'(PER12), p)
  endtask

  task automatic t_fifo;
    for (int i = 0; i < FIFO_DEPTH; i++) conv(12'h101 * i[11:0], CONV12_CYC);
    target <= 12'hEEE;
    host.pulse(3);
    repeat (CONV12_CYC + 20) @(posedge clk);
    `CHK("full stall", 1'b1, status_out)
    for (int i = 0; i < FIFO_DEPTH; i++) pop(4'hC, ~(12'h101 * i[11:0]));
    repeat (10) @(posedge clk);
    pop(4'hC, ~12'hEEE);
    `CHK("fifo empty", 1'b0, result_valid)
  endtask

  initial begin
    nrst = 1'b0;
    ext = 1'b0;
    twos = 1'b0;
    rate = RATE_12;
    sc_en = 1'b0;
    sc_idx = 4'h0;
    target = 12'h000;
    result_ready = 1'b0;
    last = 1'b1;
    repeat (4) @(posedge clk);
    `CHK("reset word", PAR_RST, par_out)
    `CHK("reset status", 1'b1, status_out)
    `CHK("reset valid", 1'b0, result_valid)
    nrst <= 1'b1;
    @(posedge clk);
    t_clk();
    t_full();
    t_twos();
    t_short();
    t_abandon();
    t_ext();
    t_fifo();
    end_sim();
  end

  initial begin
    #1000000;
    miscompares++;
    end_sim();
  end
endmodule
